// *** alarm_pkg.sv ***
// Constants and types for the surveillance alarm command handler
package alarm_pkg;
  localparam int          CMD_BITS      = 16;
  localparam int          FRAME_BITS    = 52;
  localparam int          CODE_BITS     = 64;
  localparam logic [15:0] ALARM_CMD     = 16'hE004;
  localparam logic [15:0] ALARM_CMD_INV = 16'h1FFB;
  localparam logic [15:0] CRC16_PRESET  = 16'hFFFF;
  localparam logic [15:0] CRC16_POLY    = 16'h1021;
  localparam logic [15:0] CRC16_RESIDUE = 16'h1D0F;
  localparam logic [4:0]  CRC5_SEED     = 5'h09;
  localparam logic        DR_8          = 1'b0;
  localparam logic        DR_64_3       = 1'b1;
  localparam logic [1:0]  M_FM0         = 2'h0;
  localparam logic [1:0]  M_2           = 2'h1;
  localparam logic [1:0]  M_4           = 2'h2;
  localparam logic [1:0]  M_8           = 2'h3;
  localparam logic        TREXT_NONE    = 1'b0;
  localparam logic        TREXT_PILOT   = 1'b1;
  localparam logic        HEADER_BIT    = 1'b0;
  // Frame field positions, counted from the first received bit
  localparam int          POS_DR        = 32;
  localparam int          POS_M         = 33;
  localparam int          POS_TREXT     = 35;

  typedef enum logic [2:0] {
    ST_READY     = 3'h0,
    ST_ARBITRATE = 3'h1,
    ST_REPLY     = 3'h3,
    ST_ACKED     = 3'h2,
    ST_OPEN      = 3'h6,
    ST_SECURED   = 3'h7,
    ST_KILLED    = 3'h5
  } tag_state_t;
endpackage

// *** crc16_step.sv ***
// One-bit serial CRC-16 update
`timescale 1ns/1ps
module crc16_step (
  input  wire logic [15:0] i_crc,
  input  wire logic        i_bit,
  output logic      [15:0] o_crc
);
  import alarm_pkg::*;
  logic fb;
  always_comb begin
    fb    = i_crc[15] ^ i_bit;
    o_crc = {i_crc[14:0], 1'b0} ^ (fb ? CRC16_POLY : 16'h0000);
  end
endmodule // crc16_step

// *** rfid_tag_alarm_command.sv ***
// Tag-side handler for the surveillance alarm command
// What this block does
// - Reply only when alarm flag bit set
// - Reply only from the ready state
// - Alarm code is fixed 64 bits
// - Cleared flag blocks the reply; a ready tag stays ready, no fall to arbitrate
// - Reply without prior select or query
// - Frame starts with command and its inverse
// - DR bit picks divide ratio 8 or 64/3
// - M field picks 1, 2, 4, 8 cycles
// - TRext bit picks pilot tone or none
// - Load CRC5 with 01001b before reply
// - Header zero then 64 bits MSB first
// - Flag changes apply after next power-up
`timescale 1ns/1ps
module rfid_tag_alarm_command #(
  parameter logic [63:0] ALARM_CODE = 64'hA5A5_5A5A_C3C3_3C3C
) (
  input  wire logic                    i_clock,
  input  wire logic                    i_rst,
  input  wire logic                    i_frame_start,
  input  wire logic                    i_bit_valid,
  input  wire logic                    i_bit,
  input  wire logic                    i_frame_end,
  input  wire logic                    i_preamble_seen,
  input  wire logic                    i_alarm_flag_bit,
  input  wire alarm_pkg::tag_state_t   i_state,
  input  wire logic                    i_tx_bit_req,
  output logic                         o_state_set,
  output alarm_pkg::tag_state_t        o_state_next,
  output logic                         o_tx_active,
  output logic                         o_tx_bit,
  output logic                         o_tx_done,
  output logic                         o_dr,
  output logic [1:0]                   o_m,
  output logic                         o_trext,
  output logic [4:0]                   o_crc5
);
  import alarm_pkg::*;

  initial begin
    if (FRAME_BITS != 2 * CMD_BITS + 4 + 16) begin
      $error("frame length mismatch");
    end
  end

  typedef struct packed {
    logic        flag_latched;
    logic        flag_taken;
    logic [5:0]  cnt;
    logic [35:0] shreg;
    logic [15:0] crc;
    logic        preamble;
    logic        bad_len;
    logic        state_set;
    tag_state_t  state_next;
    logic        tx_active;
    logic [6:0]  tx_idx;
    logic        tx_bit;
    logic        tx_done;
    logic        dr;
    logic [1:0]  m;
    logic        trext;
    logic [4:0]  crc5;
  } st_t;

  st_t cur_ff;
  st_t nxt_ff;
  logic [15:0] crc_new;
  logic        frame_ok;
  logic        reply_go;

  crc16_step u_crc (
    .i_crc (cur_ff.crc),
    .i_bit (i_bit),
    .o_crc (crc_new)
  );

  always_comb begin
    nxt_ff           = cur_ff;
    nxt_ff.state_set = 1'b0;
    nxt_ff.tx_done   = 1'b0;
    // Flag sampled once after power-up release
    if (!cur_ff.flag_taken) begin
      nxt_ff.flag_taken   = 1'b1;
      nxt_ff.flag_latched = i_alarm_flag_bit;
    end
    if (i_frame_start) begin
      nxt_ff.cnt      = '0;
      nxt_ff.crc      = CRC16_PRESET;
      nxt_ff.preamble = i_preamble_seen;
      nxt_ff.bad_len  = 1'b0;
    end else if (i_bit_valid) begin
      nxt_ff.crc = crc_new;
      if (cur_ff.cnt < 6'(FRAME_BITS)) begin
        nxt_ff.cnt = cur_ff.cnt + 6'h01;
        if (cur_ff.cnt < 6'(POS_TREXT + 1)) begin
          nxt_ff.shreg = {cur_ff.shreg[34:0], i_bit};
        end
      end else begin
        nxt_ff.bad_len = 1'b1;
      end
    end
    frame_ok = i_frame_end && !cur_ff.bad_len && cur_ff.preamble
               && cur_ff.cnt == 6'(FRAME_BITS)
               && cur_ff.shreg[35:20] == ALARM_CMD
               && cur_ff.shreg[19:4] == ALARM_CMD_INV
               && cur_ff.crc == CRC16_RESIDUE;
    reply_go = 1'b0;
    if (frame_ok && !cur_ff.tx_active) begin
      unique case (i_state)
        ST_READY: begin
          reply_go = cur_ff.flag_latched;
        end
        ST_ARBITRATE, ST_REPLY, ST_ACKED: begin
          nxt_ff.state_set  = 1'b1;
          nxt_ff.state_next = ST_ARBITRATE;
        end
        ST_OPEN, ST_SECURED, ST_KILLED: begin
          nxt_ff.state_set = 1'b0;
        end
        default: begin
          nxt_ff.state_set = 1'b0;
        end
      endcase
    end
    if (reply_go) begin
      nxt_ff.tx_active = 1'b1;
      nxt_ff.tx_idx    = '0;
      nxt_ff.tx_bit    = HEADER_BIT;
      nxt_ff.crc5      = CRC5_SEED;
      nxt_ff.dr        = cur_ff.shreg[3];
      nxt_ff.m         = cur_ff.shreg[2:1];
      nxt_ff.trext     = cur_ff.shreg[0];
    end else if (cur_ff.tx_active && i_tx_bit_req) begin
      if (cur_ff.tx_idx == 7'(CODE_BITS)) begin
        nxt_ff.tx_active = 1'b0;
        nxt_ff.tx_done   = 1'b1;
        nxt_ff.tx_bit    = 1'b0;
      end else begin
        nxt_ff.tx_idx = cur_ff.tx_idx + 7'h01;
        nxt_ff.tx_bit = ALARM_CODE[6'(CODE_BITS - 1) - cur_ff.tx_idx[5:0]];
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      cur_ff            <= '0;
      cur_ff.crc        <= CRC16_PRESET;
      cur_ff.state_next <= ST_READY;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign o_state_set  = cur_ff.state_set;
  assign o_state_next = cur_ff.state_next;
  assign o_tx_active  = cur_ff.tx_active;
  assign o_tx_bit     = cur_ff.tx_bit;
  assign o_tx_done    = cur_ff.tx_done;
  assign o_dr         = cur_ff.dr;
  assign o_m          = cur_ff.m;
  assign o_trext      = cur_ff.trext;
  assign o_crc5       = cur_ff.crc5;

  sequence s_go;
    frame_ok && !cur_ff.tx_active && i_state == ST_READY && cur_ff.flag_latched;
  endsequence

  a_reply_start: assert property (@(posedge i_clock) disable iff (i_rst)
    s_go |=> o_tx_active && o_tx_bit == HEADER_BIT && o_crc5 == CRC5_SEED)
    else $error("reply did not start with header and seed");
  a_flag_gate: assert property (@(posedge i_clock) disable iff (i_rst)
    $rose(o_tx_active) |-> $past(cur_ff.flag_latched))
    else $error("reply without alarm flag");
  a_ready_only: assert property (@(posedge i_clock) disable iff (i_rst)
    $rose(o_tx_active) |-> $past(i_state) == ST_READY)
    else $error("reply outside ready state");
  a_flag_clear: assert property (@(posedge i_clock) disable iff (i_rst)
    !cur_ff.flag_latched |=> !$rose(o_tx_active))
    else $error("reply with cleared flag");
  a_frame_check: assert property (@(posedge i_clock) disable iff (i_rst)
    $rose(o_tx_active) |-> $past(cur_ff.crc) == CRC16_RESIDUE
                        && $past(cur_ff.shreg[19:4]) == ALARM_CMD_INV)
    else $error("reply to bad frame");
  a_arb_fall: assert property (@(posedge i_clock) disable iff (i_rst)
    frame_ok && !cur_ff.tx_active && (i_state == ST_REPLY || i_state == ST_ACKED)
    |=> o_state_set && o_state_next == ST_ARBITRATE)
    else $error("no fall to arbitrate");
  a_link_params: assert property (@(posedge i_clock) disable iff (i_rst)
    s_go |=> o_dr == $past(cur_ff.shreg[3]) && o_m == $past(cur_ff.shreg[2:1])
             && o_trext == $past(cur_ff.shreg[0]))
    else $error("link parameters not taken");
  a_first_bit: assert property (@(posedge i_clock) disable iff (i_rst)
    o_tx_active && i_tx_bit_req && cur_ff.tx_idx == 7'h00
    |=> o_tx_bit == ALARM_CODE[63])
    else $error("code not MSB first");
  a_preamble: assert property (@(posedge i_clock) disable iff (i_rst)
    $rose(o_tx_active) |-> $past(cur_ff.preamble))
    else $error("reply without preamble");
  a_no_state_ready: assert property (@(posedge i_clock) disable iff (i_rst)
    s_go |=> !o_state_set)
    else $error("ready state changed");
  a_state_pulse: assert property (@(posedge i_clock) disable iff (i_rst)
    o_state_set |=> !o_state_set)
    else $error("state load longer than one cycle");
  a_state_target: assert property (@(posedge i_clock) disable iff (i_rst)
    o_state_set |-> o_state_next == ST_ARBITRATE)
    else $error("state load to wrong state");
  a_done_pulse: assert property (@(posedge i_clock) disable iff (i_rst)
    o_tx_done |-> !o_tx_active ##1 !o_tx_done)
    else $error("reply end not a single pulse");
  a_done_after: assert property (@(posedge i_clock) disable iff (i_rst)
    o_tx_active && i_tx_bit_req && cur_ff.tx_idx == 7'(CODE_BITS)
    |=> o_tx_done && !o_tx_active)
    else $error("reply did not end after last bit");
  a_seed_stable: assert property (@(posedge i_clock) disable iff (i_rst)
    o_tx_active && !$rose(o_tx_active) |-> o_crc5 == CRC5_SEED)
    else $error("seed changed during reply");
endmodule // rfid_tag_alarm_command

// *** reader_model.sv ***
// Interrogator model: sends command frames and pulls reply bits
`timescale 1ns/1ps
module reader_model (
  input  wire logic i_clock,
  output logic      o_frame_start,
  output logic      o_bit_valid,
  output logic      o_bit,
  output logic      o_frame_end,
  output logic      o_preamble_seen,
  output logic      o_tx_bit_req
);
  initial {o_frame_start, o_bit_valid, o_bit, o_frame_end, o_preamble_seen, o_tx_bit_req} = 6'h00;
  task automatic send(input logic [35:0] pl, input logic bad, input logic pre);
    logic [15:0] c;
    logic [51:0] f;
    c = 16'hFFFF;
    for (int i = 35; i >= 0; i--) c = {c[14:0], 1'h0} ^ ((c[15] ^ pl[i]) ? 16'h1021 : 16'h0000);
    f = {pl, ~c ^ {15'h0000, bad}};
    @(posedge i_clock);
    o_preamble_seen <= pre;
    o_frame_start   <= 1'h1;
    for (int i = 51; i >= 0; i--) begin
      @(posedge i_clock);
      o_frame_start <= 1'h0;
      o_bit_valid   <= 1'h1;
      o_bit         <= f[i];
    end
    @(posedge i_clock);
    {o_bit_valid, o_frame_end, o_bit} <= {1'h0, 1'h1, ~f[0]};
    @(posedge i_clock);
    o_frame_end <= 1'h0;
  endtask
  task automatic req_bit(input int gap);
    repeat (gap) @(posedge i_clock);
    @(posedge i_clock);
    o_tx_bit_req <= 1'h1;
    @(posedge i_clock);
    o_tx_bit_req <= 1'h0;
  endtask
endmodule // reader_model

// *** rfid_tag_alarm_command_tb.sv ***
// Self-checking bench for the surveillance alarm command handler
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %s expected %0h seen %0h", n, e, g); end end
module rfid_tag_alarm_command_tb;
  import alarm_pkg::*;
  localparam logic [63:0] CODE = 64'h0F1E_2D3C_4B5A_6978;
  logic i_clock = 1'h0, i_rst = 1'h1, i_alarm_flag_bit = 1'h1;
  logic fs, bv, bt, fe, ps, rq, set, act, txb, done, dr, trext;
  logic [1:0] m;
  logic [4:0] crc5;
  tag_state_t i_state = ST_READY, nxt;
  tag_state_t sts[7] = '{ST_READY, ST_ARBITRATE, ST_REPLY, ST_ACKED, ST_OPEN, ST_SECURED, ST_KILLED};
  int errors = 0, comparisons = 0, cycles = 0, seed = 51973, n;
  logic flag_lat;
  logic [3:0] e_lnk;
  logic [31:0] r;
  always #25 i_clock = ~i_clock;
  reader_model rdr (.i_clock(i_clock), .o_frame_start(fs), .o_bit_valid(bv), .o_bit(bt),
    .o_frame_end(fe), .o_preamble_seen(ps), .o_tx_bit_req(rq));
  rfid_tag_alarm_command #(.ALARM_CODE(CODE)) dut (.i_clock(i_clock), .i_rst(i_rst),
    .i_frame_start(fs), .i_bit_valid(bv), .i_bit(bt), .i_frame_end(fe), .i_preamble_seen(ps),
    .i_alarm_flag_bit(i_alarm_flag_bit), .i_state(i_state), .i_tx_bit_req(rq),
    .o_state_set(set), .o_state_next(nxt), .o_tx_active(act), .o_tx_bit(txb),
    .o_tx_done(done), .o_dr(dr), .o_m(m), .o_trext(trext), .o_crc5(crc5));
  task automatic conclude();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic do_reset(input logic flag);
    @(posedge i_clock);
    i_rst            <= 1'h1;
    i_alarm_flag_bit <= flag;
    repeat (6) @(posedge i_clock);
    i_rst <= 1'h0;
    repeat (2) @(posedge i_clock);
    flag_lat = flag;
    e_lnk    = 4'h0;
  endtask
  task automatic frame(input tag_state_t s, input logic [35:0] pl, input logic bad,
                       input logic pre);
    logic [63:0] got;
    logic rep, stp, good;
    i_state <= s;
    good = pre && !bad && pl[35:20] == 16'hE004 && pl[19:4] == 16'h1FFB;
    rep = good && flag_lat && s == ST_READY;
    stp = good && (s == ST_ARBITRATE || s == ST_REPLY || s == ST_ACKED);
    if (rep) e_lnk = pl[3:0];
    rdr.send(pl, bad, pre);
    @(negedge i_clock);
    `CHK("tx_active", rep, act)
    `CHK("state_set", stp, set)
    if (stp) `CHK("state_next", ST_ARBITRATE, nxt)
    `CHK("link", e_lnk, {dr, m, trext})
    if (rep) begin
      `CHK("crc5", 5'h09, crc5)
      `CHK("header", 1'h0, txb)
      for (int k = 63; k >= 0; k--) begin
        rdr.req_bit(k % 3);
        @(negedge i_clock);
        got[k] = txb;
      end
      `CHK("code", CODE, got)
      rdr.req_bit(0);
      @(negedge i_clock);
      `CHK("end", 2'h1, {act, done})
    end
    @(negedge i_clock);
    `CHK("idle", 2'h0, {act, done})
  endtask
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      conclude();
    end
  end
  initial begin
    do_reset(1'h1);
    for (n = 0; n < 16; n++) begin
      r = $random(seed);
      frame(n < 5 ? ST_READY : sts[r[6:4] % 7], {16'hE004, 16'h1FFB, r[0], n[1:0], r[1]},
            1'h0, 1'h1);
    end
    frame(ST_READY, {16'hE004, 16'h1FFB, 4'hB}, 1'h1, 1'h1);
    frame(ST_READY, {16'hE004, 16'h1FFA, 4'hB}, 1'h0, 1'h1);
    frame(ST_READY, {16'hE004, 16'h1FFB, 4'hB}, 1'h0, 1'h0);
    i_alarm_flag_bit <= 1'h0;
    frame(ST_READY, {16'hE004, 16'h1FFB, 4'h6}, 1'h0, 1'h1);
    do_reset(1'h0);
    frame(ST_READY, {16'hE004, 16'h1FFB, 4'h9}, 1'h0, 1'h1);
    conclude();
  end
endmodule // rfid_tag_alarm_command_tb
